// File: hdl/sbra_slave.v
// Purpose: two-wire slave with block reads, atomic 16-bit access, reset line handling
// Assumes: scl, sda, reset line and address select are asynchronous pins
// Notes: open-drain pins drive low only; the output enables are active low
//
// How it works
// - command F2h-FDh after write address is acked and picks a preset start
// - fixed block read sends a command-dependent byte count before the data
// - plain block read starts at written pointer, no count, pointer steps by one
// - bytes beyond the implemented space read as zero
// - read pointer never wraps from the top back to zero
// - data keeps coming as long as the master acknowledges
// - on a master not-acknowledge the slave releases sda
// - low byte read freezes high byte; high byte read returns it and unfreezes
// - low byte read of another pair moves the freeze to that pair
// - low byte write is buffered and committed with the same pair's high byte
// - low byte write of another pair discards the old buffered byte
// - high byte write without matching buffered low byte is not acknowledged
// - after power-up the reset line is driven low, then becomes an input
// - reset line held low clears lock and forces deep sleep after set time
// - forced deep sleep applies deep sleep event masking
// - power-on reset inits setup region; external reset only lock and sleep
// - slave address chosen from the three-level select at first bus activity
`timescale 1ns/1ps
`include "sbra_defines.vh"

module sbra_slave (
  input wire sys_clk, // 200 MHz system clock
  input wire reset, // power-on reset, synchronous, active high
  input wire scl_in, // bus clock pin level
  input wire sda_in, // bus data pin level
  output wire sda_out, // bus data drive level, always low
  output reg sda_oe_n, // low while pulling sda low
  input wire rst_line_in, // reset line pin level
  output wire rst_line_out, // reset line drive level, always low
  output reg rst_line_oe_n, // low while pulling the reset line low
  input wire [1:0] addr_sel_code, // three-level select as 00 low, 01 mid, 1x high
  input wire [7:0] loc_addr, // local port address
  input wire [7:0] loc_wdata, // local port write data
  input wire loc_wr, // local port write strobe
  input wire loc_rd, // local port read strobe
  output reg [7:0] loc_rdata, // local port read data, valid the cycle after loc_rd
  output reg cfg_lock, // configuration write-protect bit
  output reg global_event_mask_bit, // global event mask bit
  output reg deep_sleep_state // high while sleep control holds deep sleep, masks its events
);

  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_RX = 5'b00010;
  localparam [4:0] S_RXACK = 5'b00100;
  localparam [4:0] S_TX = 5'b01000;
  localparam [4:0] S_TXACK = 5'b10000;

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  reg scl_m_reg, scl_s_reg, scl_q_reg, sda_m_reg, sda_s_reg, sda_q_reg, rst_m_reg, rst_s_reg;
  reg [1:0] sel_m_reg, sel_s_reg;

  always @(posedge sys_clk)
  begin
    scl_m_reg <= scl_in;
    scl_s_reg <= scl_m_reg;
    scl_q_reg <= scl_s_reg;
    sda_m_reg <= sda_in;
    sda_s_reg <= sda_m_reg;
    sda_q_reg <= sda_s_reg;
    rst_m_reg <= rst_line_in;
    rst_s_reg <= rst_m_reg;
    sel_m_reg <= addr_sel_code;
    sel_s_reg <= sel_m_reg;
  end

  wire scl_rise = scl_s_reg & ~scl_q_reg;
  wire scl_fall = ~scl_s_reg & scl_q_reg;
  wire start_ev = scl_s_reg & scl_q_reg & sda_q_reg & ~sda_s_reg;
  wire stop_ev = scl_s_reg & scl_q_reg & ~sda_q_reg & sda_s_reg;
  assign sda_out = 1'b0;
  assign rst_line_out = 1'b0;

  // ----------------------------------------
  // reset line: power-on pulse and external detection
  // ----------------------------------------
  reg [11:0] por_cnt_reg, ext_cnt_reg;
  reg ext_armed_reg, ext_apply_reg;

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      por_cnt_reg <= 12'h000;
      rst_line_oe_n <= 1'b0;
      ext_cnt_reg <= 12'h000;
      ext_armed_reg <= 1'b0;
      ext_apply_reg <= 1'b0;
    end
    else
    begin
      ext_apply_reg <= 1'b0;
      if (!rst_line_oe_n)
      begin
        if (por_cnt_reg == `SBRA_POR_PULSE_CYC - 1)
          rst_line_oe_n <= 1'b1;
        else
          por_cnt_reg <= por_cnt_reg + 12'h001;
      end
      else if (ext_armed_reg)
      begin
        // once detected, the request completes even if the line goes high early
        if (ext_cnt_reg == `SBRA_EXT_APPLY_CYC - 1)
        begin
          ext_apply_reg <= 1'b1;
          ext_armed_reg <= 1'b0;
          ext_cnt_reg <= 12'h000;
        end
        else
          ext_cnt_reg <= ext_cnt_reg + 12'h001;
      end
      else if (!rst_s_reg)
      begin
        ext_cnt_reg <= ext_cnt_reg + 12'h001;
        if (ext_cnt_reg == `SBRA_EXT_DETECT_CYC - 1)
          ext_armed_reg <= 1'b1;
      end
      else
        ext_cnt_reg <= 12'h000;
    end
  end

  // ----------------------------------------
  // link engine, register space and 16-bit access
  // ----------------------------------------
  reg [7:0] mem [0:63];
  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] sh_reg, fix_cnt_reg, frz_byte_reg, lb_byte_reg, tx_next;
  reg first_reg, rw_reg, wr_data_reg, mack_reg, cnt_pend_reg, frz_valid_reg, lb_valid_reg, addr_latched_reg;
  reg [8:0] ptr_reg;
  reg [2:0] frz_idx_reg, lb_idx_reg;
  reg [6:0] slave_addr_reg, sel_addr;
  integer i;

  wire in_space = ptr_reg < `SBRA_SPACE_SIZE;
  wire is_lo16 = (ptr_reg[8:4] == `SBRA_W16_TAG) & ~ptr_reg[0];
  wire is_hi16 = (ptr_reg[8:4] == `SBRA_W16_TAG) & ptr_reg[0];
  wire frz_hit = frz_valid_reg & (frz_idx_reg == ptr_reg[3:1]);
  wire lb_hit = lb_valid_reg & (lb_idx_reg == ptr_reg[3:1]);
  wire [8:0] ptr_inc = (ptr_reg == `SBRA_PTR_END) ? ptr_reg : ptr_reg + 9'h001;
  wire is_fix_cmd = (sh_reg >= `SBRA_FIX_CMD_FIRST) & (sh_reg <= `SBRA_FIX_CMD_LAST);
  wire [3:0] fix_idx = sh_reg[3:0] - 4'h2;
  wire load_tx = scl_fall & (((state_reg == S_RXACK) & rw_reg & ~wr_data_reg) | ((state_reg == S_TXACK) & mack_reg));

  always @*
  begin
    tx_next = 8'h00;
    if (cnt_pend_reg)
      tx_next = fix_cnt_reg;
    else if (in_space)
    begin
      if (is_hi16 && frz_hit)
        tx_next = frz_byte_reg;
      else
        tx_next = mem[ptr_reg[5:0]];
    end
  end

  always @*
  begin
    case (sel_s_reg)
      `SBRA_SEL_LOW: sel_addr = `SBRA_ADDR_LOW;
      `SBRA_SEL_MID: sel_addr = `SBRA_ADDR_MID;
      default: sel_addr = `SBRA_ADDR_HIGH;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (i = 0; i < `SBRA_POR_REGION; i = i + 1)
        mem[i] <= 8'h00;
      mem[`SBRA_CFG_OFS] <= `SBRA_CFG_RESET;
      mem[`SBRA_SLEEP_OFS] <= `SBRA_SLEEP_RESET;
      state_reg <= S_IDLE;
      wr_data_reg <= 1'b0;
      ptr_reg <= 9'h000;
      cnt_pend_reg <= 1'b0;
      frz_valid_reg <= 1'b0;
      lb_valid_reg <= 1'b0;
      addr_latched_reg <= 1'b0;
      slave_addr_reg <= `SBRA_ADDR_LOW;
      sda_oe_n <= 1'b1;
      loc_rdata <= 8'h00;
      cfg_lock <= 1'b0;
      global_event_mask_bit <= 1'b1;
      deep_sleep_state <= 1'b1;
    end
    else
    begin
      if (loc_rd)
        loc_rdata <= (loc_addr == `SBRA_LOC_STATUS_OFS) ? {addr_latched_reg, slave_addr_reg} :
                     ({1'b0, loc_addr} < `SBRA_SPACE_SIZE) ? mem[loc_addr[5:0]] : 8'h00;
      if (loc_wr && ({1'b0, loc_addr} < `SBRA_SPACE_SIZE))
        mem[loc_addr[5:0]] <= loc_wdata;
      if (stop_ev)
      begin
        state_reg <= S_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (start_ev)
      begin
        state_reg <= S_RX;
        bit_cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        sda_oe_n <= 1'b1;
        if (!addr_latched_reg)
        begin
          addr_latched_reg <= 1'b1;
          slave_addr_reg <= sel_addr;
        end
      end
      else
      begin
        case (state_reg)
          S_RX:
          begin
            if (scl_rise && bit_cnt_reg != 4'h8)
            begin
              sh_reg <= {sh_reg[6:0], sda_s_reg};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              bit_cnt_reg <= 4'h0;
              state_reg <= S_RXACK;
              sda_oe_n <= 1'b0;
              if (first_reg)
              begin
                first_reg <= 1'b0;
                rw_reg <= sh_reg[0];
                wr_data_reg <= 1'b0;
                if (sh_reg[7:1] != slave_addr_reg)
                begin
                  state_reg <= S_IDLE;
                  sda_oe_n <= 1'b1;
                end
              end
              else if (!wr_data_reg)
              begin
                wr_data_reg <= 1'b1;
                if (is_fix_cmd)
                begin
                  // preset start is the fix base plus twice the index; only F2h-F9h land in the 16-bit value area
                  ptr_reg <= `SBRA_FIX_BASE + {4'h0, fix_idx, 1'b0};
                  fix_cnt_reg <= fix_idx[3] ? `SBRA_FIX_CNT_QUAD : `SBRA_FIX_CNT_PAIR;
                  cnt_pend_reg <= 1'b1;
                end
                else
                begin
                  ptr_reg <= {1'b0, sh_reg};
                  cnt_pend_reg <= 1'b0;
                end
              end
              else
              begin
                ptr_reg <= ptr_inc;
                if (in_space && is_lo16)
                begin
                  lb_byte_reg <= sh_reg;
                  lb_idx_reg <= ptr_reg[3:1];
                  lb_valid_reg <= 1'b1;
                end
                else if (in_space && is_hi16)
                begin
                  if (lb_hit)
                  begin
                    mem[{ptr_reg[5:1], 1'b0}] <= lb_byte_reg;
                    mem[ptr_reg[5:0]] <= sh_reg;
                    lb_valid_reg <= 1'b0;
                  end
                  else
                    sda_oe_n <= 1'b1;
                end
                else if (in_space && !(cfg_lock && ptr_reg >= `SBRA_LOCK_FIRST && ptr_reg <= `SBRA_LOCK_LAST))
                  mem[ptr_reg[5:0]] <= sh_reg;
              end
            end
          end
          S_RXACK:
          begin
            if (scl_fall && !load_tx)
            begin
              state_reg <= S_RX;
              sda_oe_n <= 1'b1;
            end
          end
          S_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_reg == 4'h7)
              begin
                bit_cnt_reg <= 4'h0;
                state_reg <= S_TXACK;
                sda_oe_n <= 1'b1;
              end
              else
              begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                sh_reg <= {sh_reg[6:0], 1'b0};
                sda_oe_n <= sh_reg[6];
              end
            end
          end
          S_TXACK:
          begin
            if (scl_rise)
              mack_reg <= ~sda_s_reg;
            else if (scl_fall && !mack_reg)
            begin
              state_reg <= S_IDLE;
              sda_oe_n <= 1'b1;
            end
          end
          default:
            sda_oe_n <= 1'b1;
        endcase
        // each acknowledged byte earns another, past any announced count
        if (load_tx)
        begin
          state_reg <= S_TX;
          sh_reg <= tx_next;
          sda_oe_n <= tx_next[7];
          wr_data_reg <= 1'b1;
          if (cnt_pend_reg)
            cnt_pend_reg <= 1'b0;
          else
          begin
            if (in_space && is_lo16)
            begin
              frz_valid_reg <= 1'b1;
              frz_idx_reg <= ptr_reg[3:1];
              frz_byte_reg <= mem[{ptr_reg[5:1], 1'b1}];
            end
            else if (is_hi16 && frz_hit)
              frz_valid_reg <= 1'b0;
            ptr_reg <= ptr_inc;
          end
        end
      end
      if (ext_apply_reg)
      begin
        mem[`SBRA_CFG_OFS][`SBRA_CFG_LOCK_BIT] <= 1'b0;
        mem[`SBRA_SLEEP_OFS] <= `SBRA_SLEEP_DEEP;
      end
      cfg_lock <= mem[`SBRA_CFG_OFS][`SBRA_CFG_LOCK_BIT];
      global_event_mask_bit <= mem[`SBRA_CFG_OFS][`SBRA_CFG_GMASK_BIT];
      deep_sleep_state <= (mem[`SBRA_SLEEP_OFS] == `SBRA_SLEEP_DEEP);
    end
  end

endmodule

// File: shared/sbra_defines.vh
// Purpose: constants of the slave-side register access block
// Assumes: 200 MHz system clock
// Notes: offsets are register pointer values on the two-wire link, except the local status offset of the local port
`ifndef SBRA_DEFINES_VH
`define SBRA_DEFINES_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define SBRA_CLK_PERIOD_NS 5
`define SBRA_POR_PULSE_NS 1000
`define SBRA_POR_PULSE_CYC ((`SBRA_POR_PULSE_NS + `SBRA_CLK_PERIOD_NS - 1) / `SBRA_CLK_PERIOD_NS)
`define SBRA_EXT_DETECT_NS 4000
`define SBRA_EXT_DETECT_CYC ((`SBRA_EXT_DETECT_NS + `SBRA_CLK_PERIOD_NS - 1) / `SBRA_CLK_PERIOD_NS)
`define SBRA_EXT_APPLY_NS 10000
`define SBRA_EXT_APPLY_CYC (`SBRA_EXT_APPLY_NS / `SBRA_CLK_PERIOD_NS)

// ----------------------------------------
// register space
// ----------------------------------------
`define SBRA_SPACE_SIZE 9'h040
`define SBRA_PTR_END 9'h100
`define SBRA_POR_REGION 32
`define SBRA_CFG_OFS 6'h00
`define SBRA_CFG_LOCK_BIT 0
`define SBRA_CFG_GMASK_BIT 1
`define SBRA_CFG_RESET 8'h02
`define SBRA_SLEEP_OFS 6'h01
`define SBRA_SLEEP_RESET 8'h04
`define SBRA_SLEEP_DEEP 8'h04
`define SBRA_LOCK_FIRST 9'h002
`define SBRA_LOCK_LAST 9'h01f
`define SBRA_W16_TAG 5'h02
`define SBRA_LOC_STATUS_OFS 8'hff

// ----------------------------------------
// fixed block commands and addresses
// ----------------------------------------
`define SBRA_FIX_CMD_FIRST 8'hf2
`define SBRA_FIX_CMD_LAST 8'hfd
`define SBRA_FIX_BASE 9'h020
`define SBRA_FIX_CNT_PAIR 8'h02
`define SBRA_FIX_CNT_QUAD 8'h04
`define SBRA_SEL_LOW 2'b00
`define SBRA_SEL_MID 2'b01
`define SBRA_ADDR_LOW 7'h2c
`define SBRA_ADDR_MID 7'h2e
`define SBRA_ADDR_HIGH 7'h2d

`endif

// File: verification/sbra_slave_asserts.sv
// Purpose: port-level checks of the slave register access block
// Assumes: 200 MHz sys_clk, synchronous active-high reset
// Notes: windows leave room for the pin synchroniser lag
`timescale 1ns/1ps
module sbra_slave_asserts (
  input wire sys_clk, // clock
  input wire reset, // power-on reset
  input wire scl_in, // bus clock pin
  input wire sda_oe_n, // sda pull, low active
  input wire rst_line_in, // reset line pin
  input wire rst_line_oe_n, // reset line pull, low active
  input wire [7:0] loc_addr, // local address
  input wire [7:0] loc_wdata, // local write data
  input wire loc_wr, // local write
  input wire loc_rd, // local read
  input wire [7:0] loc_rdata, // local read data
  input wire cfg_lock, // lock bit
  input wire global_event_mask_bit, // global mask
  input wire deep_sleep_state // deep sleep
);
  // ------
  // helper counters
  // ------
  logic [11:0] rel_cnt;
  logic [11:0] low_cnt;
  always @(posedge sys_clk)
  begin
    if (reset)
      rel_cnt <= 12'h000;
    else if (rel_cnt != 12'hfff)
      rel_cnt <= rel_cnt + 12'h001;
    if (reset || rst_line_in)
      low_cnt <= 12'h000;
    else if (low_cnt != 12'hfff)
      low_cnt <= low_cnt + 12'h001;
  end
  // ------
  // checks
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  por_pulse_low_a: assert property (rel_cnt < 12'h0be |-> !rst_line_oe_n)
    else $error("reset line released early");
  por_pulse_end_a: assert property (rel_cnt > 12'h0d2 |-> rst_line_oe_n)
    else $error("reset line still driven");
  reset_state_a: assert property ($fell(reset) |-> !cfg_lock && global_event_mask_bit && deep_sleep_state && sda_oe_n)
    else $error("bad state after reset");
  void_read_a: assert property (loc_rd && loc_addr > 8'h3f && loc_addr != 8'hff |=> loc_rdata == 8'h00)
    else $error("unmapped read not zero");
  lock_write_a: assert property (loc_wr && loc_addr == 8'h00 && loc_wdata[1:0] == 2'h3 |-> ##2 cfg_lock && global_event_mask_bit)
    else $error("config bits not written");
  ext_reset_a: assert property (low_cnt == 12'h7da |-> !cfg_lock && deep_sleep_state)
    else $error("external reset not applied");
  early_clear_a: assert property (low_cnt > 12'h000 && low_cnt < 12'h7b0 |-> $stable(cfg_lock) && $stable(deep_sleep_state))
    else $error("external reset applied early");
  sda_turn_a: assert property ($changed(sda_oe_n) && !$past(reset) |-> !scl_in)
    else $error("sda moved while scl high");
  cover property (low_cnt == 12'h7da);
  cover property ($rose(rst_line_oe_n));
  cover property (loc_rd && loc_addr == 8'h40);
endmodule

bind sbra_slave sbra_slave_asserts chk (.sys_clk, .reset, .scl_in, .sda_oe_n, .rst_line_in, .rst_line_oe_n,
  .loc_addr, .loc_wdata, .loc_wr, .loc_rd, .loc_rdata, .cfg_lock, .global_event_mask_bit, .deep_sleep_state);

// File: verification/sbra_i2c_master.sv
// Purpose: behavioural two-wire bus master for the slave block
// Assumes: 160 ns bus clock period, pull-up on sda
// Notes: sole master on the bus; scl stands high between frames
`timescale 1ns/1ps
module sbra_i2c_master (
  output logic scl_line, // bus clock
  output logic sda_low, // high while pulling sda low
  input wire sda // resolved sda level
);
  // ------
  // bus primitives
  // ------
  initial
  begin
    scl_line = 1'b1;
    sda_low = 1'b0;
  end
  // the trailing wait keeps the next data edge clear of the scl fall
  task start;
  begin
    sda_low = 1'b0;
    #40 scl_line = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl_line = 1'b0;
    #40;
  end
  endtask
  task stop;
  begin
    sda_low = 1'b1;
    #40 scl_line = 1'b1;
    #40 sda_low = 1'b0;
    #40;
  end
  endtask
  task bitx(input logic b, output logic r);
  begin
    sda_low = !b;
    #40 scl_line = 1'b1;
    #40 r = sda;
    #40 scl_line = 1'b0;
    #40;
  end
  endtask
  // sending ff leaves sda to the slave during the data bits
  task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic b;
  begin
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], b);
      q[i] = b;
    end
    bitx(ack_in, ack);
  end
  endtask
endmodule

// File: verification/sbra_slave_bench.sv
// Purpose: self-checking bench for the slave register access block
// Assumes: 5 ns sys_clk, 160 ns bus clock
// Notes: address cases first, then local rows, link, reset line and power-on cases
`timescale 1ns/1ps
module sbra_slave_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr_sel_code = 2'b01;
  logic [7:0] loc_addr = 8'h00;
  logic [7:0] loc_wdata = 8'h00;
  logic loc_wr = 1'b0;
  logic loc_rd = 1'b0;
  logic ext_low = 1'b0;
  logic [6:0] dev;
  wire scl_line;
  wire sda_low;
  wire sda_oe_n;
  wire rst_line_oe_n;
  wire [7:0] loc_rdata;
  wire cfg_lock;
  wire deep_sleep_state;
  wire sda = (!sda_oe_n || sda_low) ? 1'b0 : 1'b1;
  wire rst_line = (!rst_line_oe_n || ext_low) ? 1'b0 : 1'b1;
  int failures = 0;
  int n_checks = 0;
  // {write, address, data, expected read}
  logic [24:0] rows [0:9] = '{25'h0000002, 25'h0010004, 25'h0020000, 25'h01f0000, 25'h13cc300,
    25'h03c00c3, 25'h0400000, 25'h1415a00, 25'h0410000, 25'h0fe0000};
  logic [1:0] sel_tab [0:2] = '{2'b00, 2'b01, 2'b10};
  logic [6:0] addr_tab [0:2] = '{7'h2c, 7'h2e, 7'h2d};
  always #2.5 sys_clk = ~sys_clk;
  sbra_i2c_master m (.scl_line(scl_line), .sda_low(sda_low), .sda(sda));
  sbra_slave dut (.sys_clk, .reset, .scl_in(scl_line), .sda_in(sda), .sda_out(), .sda_oe_n,
    .rst_line_in(rst_line), .rst_line_out(), .rst_line_oe_n, .addr_sel_code, .loc_addr, .loc_wdata,
    .loc_wr, .loc_rd, .loc_rdata, .cfg_lock, .global_event_mask_bit(), .deep_sleep_state);
  // ------
  // tasks
  // ------
  task chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task por(input logic [1:0] s);
  begin
    @(posedge sys_clk);
    reset <= 1'b1;
    addr_sel_code <= s;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
  end
  endtask
  task lwr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    loc_addr <= a;
    loc_wdata <= d;
    loc_wr <= 1'b1;
    @(posedge sys_clk);
    loc_wr <= 1'b0;
  end
  endtask
  task lrd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge sys_clk);
    loc_addr <= a;
    loc_rd <= 1'b1;
    @(posedge sys_clk);
    loc_rd <= 1'b0;
    #1 d = loc_rdata;
  end
  endtask
  // a returns the acknowledge of the last byte, 0 meaning taken
  task wrb(input logic [7:0] b[$], output logic a);
    logic [7:0] q;
  begin
    m.start;
    m.xfer({dev, 1'b0}, 1'b1, q, a);
    foreach (b[i])
      m.xfer(b[i], 1'b1, q, a);
    m.stop;
  end
  endtask
  // pointer or command, repeated start, then reads acked all but the last
  task blk(input logic [7:0] p, input logic [7:0] e[$]);
    logic [7:0] q;
    logic a;
  begin
    m.start;
    m.xfer({dev, 1'b0}, 1'b1, q, a);
    m.xfer(p, 1'b1, q, a);
    m.start;
    m.xfer({dev, 1'b1}, 1'b1, q, a);
    chk({7'h00, a}, 8'h00);
    foreach (e[i])
    begin
      m.xfer(8'hff, i == e.size() - 1, q, a);
      chk(q, e[i]);
    end
    m.stop;
    chk({7'h00, sda_oe_n}, 8'h01);
  end
  endtask
  task pulse(input int n);
  begin
    repeat (4) @(posedge sys_clk);
    ext_low <= 1'b1;
    repeat (n) @(posedge sys_clk);
    ext_low <= 1'b0;
    repeat (2200) @(posedge sys_clk);
  end
  endtask
  // ------
  // sequence
  // ------
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    $display("ERROR %0t: run too long", $time);
    give_verdict;
  end
  initial
  begin
    logic [7:0] q;
    logic a;
    logic [7:0] e[$];
    for (int s = 0; s < 3; s++)
    begin
      por(sel_tab[s]);
      dev = addr_tab[s];
      wrb('{8'h30}, a);
      chk({7'h00, a}, 8'h00);
      lrd(8'hff, q);
      chk(q, {1'b1, dev});
    end
    @(posedge sys_clk);
    addr_sel_code <= 2'b00;
    m.start;
    m.xfer({7'h2c, 1'b0}, 1'b1, q, a);
    m.stop;
    chk({7'h00, a}, 8'h01);
    $display("end of address test");
    for (int r = 0; r < 10; r++)
    begin
      if (rows[r][24])
        lwr(rows[r][23:16], rows[r][15:8]);
      else
      begin
        lrd(rows[r][23:16], q);
        chk(q, rows[r][7:0]);
      end
    end
    $display("end of row test");
    for (int i = 0; i < 16; i++)
      lwr(8'h30 + i[7:0], 8'ha0 + i[7:0]);
    blk(8'h3e, '{8'hae, 8'haf, 8'h00, 8'h00});
    blk(8'hfe, '{8'h00, 8'h00, 8'h00});
    for (int k = 8; k < 12; k++)
    begin
      e = '{8'h04};
      for (int j = 0; j < 5; j++)
        e.push_back(8'h90 + 8'(2 * k + j));
      blk(8'hf2 + 8'(k), e);
    end
    $display("end of block read test");
    wrb('{8'h20, 8'h34}, a);
    wrb('{8'h21, 8'h12}, a);
    chk({7'h00, a}, 8'h00);
    blk(8'hf2, '{8'h02, 8'h34, 8'h12});
    wrb('{8'h22, 8'haa}, a);
    wrb('{8'h24, 8'hbb}, a);
    wrb('{8'h23, 8'hcc}, a);
    chk({7'h00, a}, 8'h01);
    wrb('{8'h27, 8'hdd}, a);
    chk({7'h00, a}, 8'h01);
    wrb('{8'h24, 8'hbb}, a);
    wrb('{8'h25, 8'hee}, a);
    blk(8'h24, '{8'hbb, 8'hee});
    blk(8'h20, '{8'h34});
    wrb('{8'h20, 8'h56}, a);
    wrb('{8'h21, 8'h78}, a);
    blk(8'h21, '{8'h12});
    blk(8'h21, '{8'h78});
    blk(8'h20, '{8'h56});
    blk(8'h24, '{8'hbb});
    wrb('{8'h20, 8'h9a}, a);
    wrb('{8'h21, 8'hbc}, a);
    blk(8'h21, '{8'hbc});
    $display("end of pair test");
    lwr(8'h00, 8'h03);
    lwr(8'h01, 8'h00);
    wrb('{8'h05, 8'h77}, a);
    lrd(8'h05, q);
    chk(q, 8'h00);
    pulse(600);
    chk({7'h00, cfg_lock}, 8'h01);
    chk({7'h00, deep_sleep_state}, 8'h00);
    pulse(2100);
    chk({7'h00, cfg_lock}, 8'h00);
    chk({7'h00, deep_sleep_state}, 8'h01);
    lrd(8'h00, q);
    chk(q, 8'h02);
    lrd(8'h01, q);
    chk(q, 8'h04);
    lrd(8'h30, q);
    chk(q, 8'ha0);
    $display("end of reset line test");
    lwr(8'h02, 8'h11);
    por(2'b00);
    lrd(8'h02, q);
    chk(q, 8'h00);
    $display("end of power-on test");
    give_verdict;
  end
endmodule
